/* File: rtl/i2c_data_path.sv */
// Data path and status flags of a two-wire serial interface behind an AXI4-Lite slave.
// Assumes SCL is made elsewhere; SCL and SDA arrive asynchronously and are filtered here.
//
// Function
// - receive_full_flag (bit 5) sets when a received byte moves into rx_holding
// - receive_full_flag clears on write 0 after reading 1, or reading rx_holding
// - no_ack_flag (bit 4) sets on missing acknowledge while ack_check_enable is 1
// - no_ack_flag clears only on write 0 after reading it as 1
// - master mode: stop flag (bit 3) sets on stop after a completed frame
// - slave mode: stop flag sets on stop after first byte matched own_slave_address
// - stop flag clears on write 0 after reading it as 1
// - tx_holding is read/write; a free shifter takes its byte and starts sending
// - a byte written during shifting follows the current one without a gap
// - rx_holding takes each received byte, is read-only, resets to zero
// - bus_shifter is hidden from software and shifts transmit data out on SDA
`timescale 1ns/10ps
module i2c_data_path
(
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [i2c_dp_pkg::AXI_ADDR_W-1:0] s_awaddr_i,
  input wire logic s_awvalid_i,
  output logic s_awready_o,
  input wire logic [31:0] s_wdata_i,
  input wire logic [3:0] s_wstrb_i,
  input wire logic s_wvalid_i,
  output logic s_wready_o,
  output logic [1:0] s_bresp_o,
  output logic s_bvalid_o,
  input wire logic s_bready_i,
  input wire logic [i2c_dp_pkg::AXI_ADDR_W-1:0] s_araddr_i,
  input wire logic s_arvalid_i,
  output logic s_arready_o,
  output logic [31:0] s_rdata_o,
  output logic [1:0] s_rresp_o,
  output logic s_rvalid_o,
  input wire logic s_rready_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  output logic irq_o
);
  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [2:0] scl_sync, sda_sync;
  logic scl_f, sda_f, scl_q, sda_q, next_scl_f, next_sda_f;
  logic scl_rise, scl_fall, start_ev, stop_ev;
  i2c_dp_pkg::link_state_e state, next_state;
  logic [2:0] cnt, next_cnt;
  logic [7:0] shifter, next_shifter, tx_holding, next_tx_holding;
  logic [7:0] rx_holding, next_rx_holding, ier, next_ier, rx_byte;
  logic [6:0] own_slave_address, next_own_slave_address;
  logic tx_pend, next_tx_pend, sh_busy, next_sh_busy;
  logic ctrl_transmit, next_ctrl_transmit, ctrl_master, next_ctrl_master;
  logic first_byte, next_first_byte, addr_match, next_addr_match;
  logic frame_done, next_frame_done, next_sda_oe, next_irq;
  logic [2:0] flags, next_flags, seen, next_seen, set_ev, clear_ev;
  logic aw_have, next_aw_have, w_have, next_w_have, w_strb0, next_w_strb0;
  logic [7:0] aw_addr, next_aw_addr, w_data, next_w_data;
  logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
  logic [1:0] next_bresp, next_rresp;
  logic [31:0] next_rdata;
  logic wr_fire, rd_fire, wr_status, rd_status, rd_rx;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  // Word-aligned match of a bus address against a register offset
  function automatic logic reg_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction

  // Any printed register; everything else answers with an error
  function automatic logic reg_mapped(input logic [7:0] a);
    return reg_hit(a, i2c_dp_pkg::ADDR_CONTROL) || reg_hit(a, i2c_dp_pkg::ADDR_IER)
      || reg_hit(a, i2c_dp_pkg::ADDR_STATUS) || reg_hit(a, i2c_dp_pkg::ADDR_OWN_ADDR)
      || reg_hit(a, i2c_dp_pkg::ADDR_TX) || reg_hit(a, i2c_dp_pkg::ADDR_RX);
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // A level is taken only once stages two and three agree, which rejects single-cycle glitches
  always_comb
  begin
    next_scl_f = (scl_sync[1] == scl_sync[2]) ? scl_sync[2] : scl_f;
    next_sda_f = (sda_sync[1] == sda_sync[2]) ? sda_sync[2] : sda_f;
  end

  // Sync chains and filtered levels
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      scl_sync <= 3'h7;
      sda_sync <= 3'h7;
      scl_f <= 1'b1;
      sda_f <= 1'b1;
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_sync <= {scl_sync[1:0], scl_i};
      sda_sync <= {sda_sync[1:0], sda_i};
      scl_f <= next_scl_f;
      sda_f <= next_sda_f;
      scl_q <= scl_f;
      sda_q <= sda_f;
    end
  end

  // Bus events from filtered levels
  assign scl_rise = scl_f && !scl_q;
  assign scl_fall = !scl_f && scl_q;
  assign start_ev = scl_f && scl_q && sda_q && !sda_f;
  assign stop_ev = scl_f && scl_q && !sda_q && sda_f;
  assign rx_byte = {shifter[6:0], sda_f};

  // ----------------------------------------
  // Register access and link engine
  // ----------------------------------------
  assign wr_fire = aw_have && w_have && !s_bvalid_o;
  assign rd_fire = s_arvalid_i && s_arready_o;
  assign wr_status = wr_fire && w_strb0 && reg_hit(aw_addr, i2c_dp_pkg::ADDR_STATUS);
  assign rd_status = rd_fire && reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_STATUS);
  assign rd_rx = rd_fire && reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_RX);

  // Next values for the bus slave, the registers, the flags and the link
  always_comb
  begin
    next_awready = s_awready_o;
    next_wready = s_wready_o;
    next_bvalid = s_bvalid_o;
    next_bresp = s_bresp_o;
    next_arready = s_arready_o;
    next_rvalid = s_rvalid_o;
    next_rresp = s_rresp_o;
    next_rdata = s_rdata_o;
    next_aw_have = aw_have;
    next_aw_addr = aw_addr;
    next_w_have = w_have;
    next_w_data = w_data;
    next_w_strb0 = w_strb0;
    next_ctrl_transmit = ctrl_transmit;
    next_ctrl_master = ctrl_master;
    next_ier = ier;
    next_own_slave_address = own_slave_address;
    next_tx_holding = tx_holding;
    next_tx_pend = tx_pend;
    next_rx_holding = rx_holding;
    next_shifter = shifter;
    next_sh_busy = sh_busy;
    next_state = state;
    next_cnt = cnt;
    next_first_byte = first_byte;
    next_addr_match = addr_match;
    next_frame_done = frame_done;
    next_sda_oe = sda_oe_o;
    set_ev = 3'h0;
    // Address and data may arrive in either order; one write at a time
    if (s_awvalid_i && s_awready_o)
    begin
      next_aw_have = 1'b1;
      next_aw_addr = s_awaddr_i;
      next_awready = 1'b0;
    end
    if (s_wvalid_i && s_wready_o)
    begin
      next_w_have = 1'b1;
      next_w_data = s_wdata_i[7:0];
      next_w_strb0 = s_wstrb_i[0];
      next_wready = 1'b0;
    end
    // A free shifter takes the pending byte, but never in mid-byte
    if (!sh_busy && tx_pend && state != i2c_dp_pkg::LINK_DATA)
    begin
      next_shifter = tx_holding;
      next_sh_busy = 1'b1;
      next_tx_pend = 1'b0;
    end
    if (wr_fire)
    begin
      next_aw_have = 1'b0;
      next_w_have = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = reg_mapped(aw_addr) ? i2c_dp_pkg::RESP_OKAY : i2c_dp_pkg::RESP_SLVERR;
      if (w_strb0)
      begin
        if (reg_hit(aw_addr, i2c_dp_pkg::ADDR_CONTROL))
        begin
          next_ctrl_transmit = w_data[i2c_dp_pkg::CTRL_TRANSMIT_BIT];
          next_ctrl_master = w_data[i2c_dp_pkg::CTRL_MASTER_BIT];
        end
        if (reg_hit(aw_addr, i2c_dp_pkg::ADDR_IER))
          next_ier = w_data;
        if (reg_hit(aw_addr, i2c_dp_pkg::ADDR_OWN_ADDR))
          next_own_slave_address = w_data[6:0];
        if (reg_hit(aw_addr, i2c_dp_pkg::ADDR_TX))
        begin
          next_tx_holding = w_data;
          next_tx_pend = 1'b1;
        end
        // Writes to rx_holding fall through here and are dropped
      end
    end
    if (s_bvalid_o && s_bready_i)
    begin
      next_bvalid = 1'b0;
      next_awready = 1'b1;
      next_wready = 1'b1;
    end
    // Read data is captured at the address handshake
    if (rd_fire)
    begin
      next_arready = 1'b0;
      next_rvalid = 1'b1;
      next_rresp = reg_mapped(s_araddr_i) ? i2c_dp_pkg::RESP_OKAY : i2c_dp_pkg::RESP_SLVERR;
      next_rdata = i2c_dp_pkg::READ_ZERO;
      if (reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_CONTROL))
      begin
        next_rdata[i2c_dp_pkg::CTRL_TRANSMIT_BIT] = ctrl_transmit;
        next_rdata[i2c_dp_pkg::CTRL_MASTER_BIT] = ctrl_master;
      end
      if (reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_IER))
        next_rdata[7:0] = ier;
      if (rd_status)
      begin
        next_rdata[i2c_dp_pkg::STOP_BIT +: i2c_dp_pkg::FLAG_COUNT] = flags;
        next_rdata[i2c_dp_pkg::TX_EMPTY_BIT] = !tx_pend;
      end
      if (reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_OWN_ADDR))
        next_rdata[6:0] = own_slave_address;
      if (reg_hit(s_araddr_i, i2c_dp_pkg::ADDR_TX))
        next_rdata[7:0] = tx_holding;
      if (rd_rx)
        next_rdata[7:0] = rx_holding;
    end
    if (s_rvalid_o && s_rready_i)
    begin
      next_rvalid = 1'b0;
      next_arready = 1'b1;
    end
    // Link engine; SDA is driven low only, the pull-up gives the ones
    case (state)
      i2c_dp_pkg::LINK_HOLD:
        if (scl_fall)
        begin
          next_state = i2c_dp_pkg::LINK_DATA;
          next_cnt = 3'h0;
          next_sda_oe = ctrl_transmit && next_sh_busy && !next_shifter[7];
        end
      i2c_dp_pkg::LINK_DATA:
        if (scl_rise && !ctrl_transmit)
        begin
          next_shifter = rx_byte;
          if (cnt == i2c_dp_pkg::LAST_BIT)
          begin
            next_rx_holding = rx_byte;
            set_ev[2] = 1'b1;
            next_first_byte = 1'b0;
            if (first_byte && !ctrl_master && rx_byte[7:1] == own_slave_address)
              next_addr_match = 1'b1;
          end
        end
        else if (scl_fall)
        begin
          if (cnt == i2c_dp_pkg::LAST_BIT)
          begin
            next_state = i2c_dp_pkg::LINK_ACK;
            if (ctrl_transmit)
              next_sh_busy = 1'b0;
            // Acknowledge only as master or once addressed
            next_sda_oe = !ctrl_transmit && (ctrl_master || next_addr_match);
          end
          else
          begin
            next_cnt = cnt + 3'h1;
            if (ctrl_transmit)
            begin
              next_shifter = {shifter[6:0], 1'b0};
              next_sda_oe = sh_busy && !shifter[6];
            end
          end
        end
      i2c_dp_pkg::LINK_ACK:
        if (scl_rise)
        begin
          next_frame_done = 1'b1;
          if (ctrl_transmit && sda_f && ier[i2c_dp_pkg::ACK_CHECK_BIT])
            set_ev[1] = 1'b1;
        end
        else if (scl_fall)
        begin
          // A byte loaded during the ack slot goes out at once
          next_state = i2c_dp_pkg::LINK_DATA;
          next_cnt = 3'h0;
          next_sda_oe = ctrl_transmit && next_sh_busy && !next_shifter[7];
        end
      default:
        next_sda_oe = 1'b0;
    endcase
    if (start_ev)
    begin
      next_state = i2c_dp_pkg::LINK_HOLD;
      next_first_byte = 1'b1;
      next_addr_match = 1'b0;
      next_frame_done = 1'b0;
      next_sda_oe = 1'b0;
    end
    if (stop_ev)
    begin
      set_ev[0] = ctrl_master ? frame_done : addr_match;
      next_state = i2c_dp_pkg::LINK_IDLE;
      next_addr_match = 1'b0;
      next_frame_done = 1'b0;
      next_sda_oe = 1'b0;
    end
  end

  // ----------------------------------------
  // Status flags and interrupt
  // ----------------------------------------
  // Clear needs a prior read of 1; writing 1 does nothing; a set beats a clear
  always_comb
  begin
    next_flags = flags;
    next_seen = seen;
    clear_ev = 3'h0;
    for (int i = 0; i < i2c_dp_pkg::FLAG_COUNT; i++)
    begin
      clear_ev[i] = wr_status && seen[i] && !w_data[i2c_dp_pkg::STOP_BIT + i];
      if (rd_status && flags[i])
        next_seen[i] = 1'b1;
      if (clear_ev[i])
      begin
        next_flags[i] = 1'b0;
        next_seen[i] = 1'b0;
      end
    end
    // A data read also voids the earlier read of 1, so a later write 0 needs a fresh read
    if (rd_rx)
    begin
      next_flags[2] = 1'b0;
      next_seen[2] = 1'b0;
    end
    for (int i = 0; i < i2c_dp_pkg::FLAG_COUNT; i++)
      if (set_ev[i])
        next_flags[i] = 1'b1;
    next_irq = |(next_flags & ier[i2c_dp_pkg::STOP_BIT +: i2c_dp_pkg::FLAG_COUNT]);
  end

  // All registered state except the sync chains and filtered levels
  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      s_awready_o <= 1'b1;
      s_wready_o <= 1'b1;
      s_bvalid_o <= 1'b0;
      s_bresp_o <= i2c_dp_pkg::RESP_OKAY;
      s_arready_o <= 1'b1;
      s_rvalid_o <= 1'b0;
      s_rresp_o <= i2c_dp_pkg::RESP_OKAY;
      s_rdata_o <= i2c_dp_pkg::READ_ZERO;
      aw_have <= 1'b0;
      aw_addr <= 8'h00;
      w_have <= 1'b0;
      w_data <= 8'h00;
      w_strb0 <= 1'b0;
      ctrl_transmit <= 1'b0;
      ctrl_master <= 1'b0;
      ier <= i2c_dp_pkg::IER_RESET;
      own_slave_address <= i2c_dp_pkg::OWN_ADDR_RESET;
      tx_holding <= i2c_dp_pkg::TX_RESET;
      tx_pend <= 1'b0;
      rx_holding <= i2c_dp_pkg::RX_RESET;
      shifter <= 8'h00;
      sh_busy <= 1'b0;
      state <= i2c_dp_pkg::LINK_IDLE;
      cnt <= 3'h0;
      first_byte <= 1'b0;
      addr_match <= 1'b0;
      frame_done <= 1'b0;
      flags <= 3'h0;
      seen <= 3'h0;
      sda_o <= 1'b0;
      sda_oe_o <= 1'b0;
      irq_o <= 1'b0;
    end
    else
    begin
      s_awready_o <= next_awready;
      s_wready_o <= next_wready;
      s_bvalid_o <= next_bvalid;
      s_bresp_o <= next_bresp;
      s_arready_o <= next_arready;
      s_rvalid_o <= next_rvalid;
      s_rresp_o <= next_rresp;
      s_rdata_o <= next_rdata;
      aw_have <= next_aw_have;
      aw_addr <= next_aw_addr;
      w_have <= next_w_have;
      w_data <= next_w_data;
      w_strb0 <= next_w_strb0;
      ctrl_transmit <= next_ctrl_transmit;
      ctrl_master <= next_ctrl_master;
      ier <= next_ier;
      own_slave_address <= next_own_slave_address;
      tx_holding <= next_tx_holding;
      tx_pend <= next_tx_pend;
      rx_holding <= next_rx_holding;
      shifter <= next_shifter;
      sh_busy <= next_sh_busy;
      state <= next_state;
      cnt <= next_cnt;
      first_byte <= next_first_byte;
      addr_match <= next_addr_match;
      frame_done <= next_frame_done;
      flags <= next_flags;
      seen <= next_seen;
      sda_o <= 1'b0;
      sda_oe_o <= next_sda_oe;
      irq_o <= next_irq;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  rx_full_set_a: assert property ((state == i2c_dp_pkg::LINK_DATA && scl_rise
    && !ctrl_transmit && cnt == i2c_dp_pkg::LAST_BIT) |=> flags[2] && rx_holding == $past(rx_byte))
    else $error("receive full flag or byte missing");
  rx_read_clear_a: assert property ((rd_rx && !set_ev[2]) |=> !flags[2])
    else $error("receive full flag kept after data read");
  nack_set_a: assert property ((state == i2c_dp_pkg::LINK_ACK && scl_rise && ctrl_transmit
    && sda_f && ier[i2c_dp_pkg::ACK_CHECK_BIT]) |=> flags[1])
    else $error("no acknowledge not flagged");
  nack_hold_a: assert property ((flags[1] && !(wr_status && seen[1]
    && !w_data[i2c_dp_pkg::NO_ACK_BIT])) |=> flags[1])
    else $error("no acknowledge flag lost without clear");
  stop_master_a: assert property ((stop_ev && ctrl_master && frame_done) |=> flags[0])
    else $error("stop after frame not flagged");
  stop_slave_a: assert property ((stop_ev && !ctrl_master && !addr_match && !flags[0])
    |=> !flags[0])
    else $error("stop flagged without address match");
  stop_clear_a: assert property ((wr_status && seen[0] && !w_data[i2c_dp_pkg::STOP_BIT]
    && !set_ev[0]) |=> !flags[0] ##1 (flags[0] == $past(set_ev[0])))
    else $error("stop flag not cleared");
  tx_load_a: assert property ((!sh_busy && tx_pend && state != i2c_dp_pkg::LINK_DATA)
    |=> sh_busy && shifter == $past(tx_holding))
    else $error("free shifter did not take byte");
  gapless_a: assert property ((state == i2c_dp_pkg::LINK_ACK && scl_fall && ctrl_transmit
    && sh_busy && !start_ev && !stop_ev) |=> state == i2c_dp_pkg::LINK_DATA && sda_oe_o == !shifter[7])
    else $error("next byte not sent straight after");
  rx_read_only_a: assert property ((wr_fire && reg_hit(aw_addr, i2c_dp_pkg::ADDR_RX)
    && !set_ev[2]) |=> $stable(rx_holding))
    else $error("rx holding changed by write");
  sda_drive_a: assert property ((state == i2c_dp_pkg::LINK_DATA && ctrl_transmit && sh_busy)
    |-> sda_oe_o == !shifter[7])
    else $error("SDA does not follow shifter");
endmodule // i2c_data_path

/* File: rtl/i2c_dp_pkg.sv */
// Constants for the two-wire data path: register map, field positions, reset values.
// Assumes a 32-bit AXI4-Lite master and byte-wide registers in the low lane.
package i2c_dp_pkg;
  // ----------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_IER = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_OWN_ADDR = 8'h0C;
  localparam logic [7:0] ADDR_TX = 8'h10;
  localparam logic [7:0] ADDR_RX = 8'h14;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CTRL_TRANSMIT_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int ACK_CHECK_BIT = 0;
  localparam int STOP_BIT = 3;
  localparam int NO_ACK_BIT = 4;
  localparam int RX_FULL_BIT = 5;
  localparam int TX_EMPTY_BIT = 7;
  localparam int FLAG_COUNT = 3;
  // ----------------------------------------
  // Reset values and codes
  // ----------------------------------------
  localparam logic [7:0] RX_RESET = 8'h00;
  localparam logic [7:0] TX_RESET = 8'h00;
  localparam logic [7:0] IER_RESET = 8'h00;
  localparam logic [6:0] OWN_ADDR_RESET = 7'h00;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] READ_ZERO = 32'h0000_0000;
  // Link position within a frame
  typedef enum logic [1:0] {LINK_IDLE, LINK_HOLD, LINK_DATA, LINK_ACK} link_state_e;
endpackage

/* File: test/i2c_far_party.sv */
// Far-side bus party: makes SCL and drives SDA open-drain.
// Assumes the bench resolves SDA with a pull-up.
`timescale 1ns/10ps
module i2c_far_party
(
  output logic scl_o,
  output logic sda_pull_o,
  input wire logic sda_i
);
  // ---------
  // Bus tasks
  // ---------
  // SCL stands high and SDA is released outside frames
  initial {scl_o, sda_pull_o} = 2'b10;
  // One 64 ns bit: 40 low, 24 high, sampled mid-high
  task automatic slot(input logic b, output logic got);
    #8 sda_pull_o = ~b;
    #32 scl_o = 1'b1;
    #12 got = sda_i;
    #12 scl_o = 1'b0;
  endtask
  // Start or stop; the late SCL rise lets an ack pull end first
  task automatic frame_edge(input logic stop);
    #1 sda_pull_o = stop;
    #40 scl_o = 1'b1;
    #12 sda_pull_o = ~stop;
    #12 scl_o = stop;
  endtask
  // Byte MSB first, then the ack slot; ack_drive 1 leaves SDA released
  task automatic xfer(input logic [7:0] o, input logic ack_drive,
    output logic [7:0] i_b, output logic ack_seen);
    #1;
    for (int i = 7; i >= 0; i--) slot(o[i], i_b[i]);
    slot(ack_drive, ack_seen);
  endtask
endmodule // i2c_far_party

/* File: test/i2c_data_path_bench.sv */
// Bench for the two-wire data path: AXI4-Lite master tasks and bus scenarios.
// Assumes i2c_dp_pkg and i2c_far_party are compiled first.
`timescale 1ns/10ps
module i2c_data_path_bench;
  localparam logic [7:0] IER = i2c_dp_pkg::ADDR_IER;
  localparam logic [7:0] ST = i2c_dp_pkg::ADDR_STATUS;
  localparam logic [7:0] TX = i2c_dp_pkg::ADDR_TX;
  localparam logic [7:0] RX = i2c_dp_pkg::ADDR_RX;
  localparam logic [31:0] F_RX = 32'h0000_0001 << i2c_dp_pkg::RX_FULL_BIT;
  localparam logic [31:0] F_NAK = 32'h0000_0001 << i2c_dp_pkg::NO_ACK_BIT;
  localparam logic [31:0] F_STP = 32'h0000_0001 << i2c_dp_pkg::STOP_BIT;
  localparam logic [31:0] F_TXE = 32'h0000_0001 << i2c_dp_pkg::TX_EMPTY_BIT;
  localparam logic [31:0] FLAGS = F_RX | F_NAK | F_STP;
  localparam logic [31:0] BYTE = 32'h0000_00FF;
  logic clk_i, reset_n_i, scl, sda_pull, sda_o, sda_oe, irq, sda_line;
  logic awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic [i2c_dp_pkg::AXI_ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, er;
  int n_fail, n_tests;
  // Open-drain SDA with pull-up: low while either party pulls
  assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
  i2c_data_path i_dut (.clk_i(clk_i), .reset_n_i(reset_n_i), .s_awaddr_i(awaddr),
    .s_awvalid_i(awvalid), .s_awready_o(awready), .s_wdata_i(wdata), .s_wstrb_i(wstrb),
    .s_wvalid_i(wvalid), .s_wready_o(wready), .s_bresp_o(bresp), .s_bvalid_o(bvalid),
    .s_bready_i(bready), .s_araddr_i(araddr), .s_arvalid_i(arvalid),
    .s_arready_o(arready), .s_rdata_o(rdata), .s_rresp_o(rresp), .s_rvalid_o(rvalid),
    .s_rready_i(rready), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .irq_o(irq));
  i2c_far_party i_link (.scl_o(scl), .sda_pull_o(sda_pull), .sda_i(sda_line));
  // 125 MHz clock
  initial
  begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  // ----------
  // Bus tasks
  // ----------
  // Verdict; a hang arrives here with hung set
  task automatic close_out(input logic hung);
    if (hung) n_fail++;
    if (hung) $display("ERROR %0t no answer within bound", $time);
    $display("tests %0d failures %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Write with both channels offered together; response must equal er
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_i);
    awaddr <= a;
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    for (n = 0; n < 64 && !(bready && bvalid); n++)
    begin
      @(posedge clk_i);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 64) close_out(1'b1);
    check(32'(bresp), 32'(er));
  endtask
  // Read, compare the masked data and the response
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    @(posedge clk_i);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    for (n = 0; n < 64 && !(rready && rvalid); n++)
    begin
      @(posedge clk_i);
      if (arready) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 64) close_out(1'b1);
    check(rdata & m, e);
    check(32'(rresp), 32'(er));
  endtask
  // Interrupt lags an enable write by a cycle, so let it settle
  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk_i);
    #1 check(32'(irq), 32'(e));
  endtask
  task automatic byte_x(input logic [7:0] o, input logic a, input logic [7:0] ei,
    input logic ea);
    logic [7:0] gi;
    logic ga;
    @(posedge clk_i);
    i_link.xfer(o, a, gi, ga);
    check(32'(gi), 32'(ei));
    check(32'(ga), 32'(ea));
  endtask
  // Start or stop, then time for the input synchronisers
  task automatic cond(input logic stop);
    @(posedge clk_i);
    i_link.frame_edge(stop);
    repeat (4) @(posedge clk_i);
  endtask
  // ---------
  // Scenarios
  // ---------
  task automatic s_reset();
    check(32'(irq), '0);
    check(32'(sda_oe), '0);
    rd_chk(RX, BYTE, 32'(i2c_dp_pkg::RX_RESET));
    rd_chk(ST, FLAGS, '0);
    wr(RX, BYTE);
    rd_chk(RX, BYTE, '0);
    wstrb <= 4'h0;
    wr(TX, 32'h0000_00EE);
    wstrb <= 4'h1;
    rd_chk(TX, BYTE, 32'(i2c_dp_pkg::TX_RESET));
    er = i2c_dp_pkg::RESP_SLVERR;
    wr(8'h40, '0);
    rd_chk(8'h40, '1, i2c_dp_pkg::READ_ZERO);
    er = i2c_dp_pkg::RESP_OKAY;
  endtask
  // Slave receive: own address, data, flag clearing, masking, stop
  task automatic s_slave();
    wr(i2c_dp_pkg::ADDR_OWN_ADDR, 32'h0000_002A);
    wr(IER, FLAGS);
    cond(1'b0);
    byte_x(8'h54, 1'b1, 8'h54, 1'b0);
    rd_chk(ST, FLAGS, F_RX);
    rd_chk(RX, BYTE, 32'h0000_0054);
    rd_chk(ST, FLAGS, '0);
    byte_x(8'hA5, 1'b1, 8'hA5, 1'b0);
    irq_chk(1'b1);
    wr(ST, '0);
    rd_chk(ST, FLAGS, F_RX);
    wr(ST, FLAGS);
    rd_chk(ST, FLAGS, F_RX);
    wr(IER, '0);
    irq_chk(1'b0);
    wr(IER, FLAGS);
    wr(ST, '0);
    rd_chk(ST, FLAGS, '0);
    irq_chk(1'b0);
    rd_chk(RX, BYTE, 32'h0000_00A5);
    cond(1'b1);
    rd_chk(ST, F_STP, F_STP);
    wr(ST, '0);
    rd_chk(ST, F_STP, '0);
    cond(1'b0);
    byte_x(8'h22, 1'b1, 8'h22, 1'b1);
    cond(1'b1);
    rd_chk(ST, F_STP, '0);
  endtask
  // Master transmit: load, back-to-back bytes, missing ack, stop flag
  task automatic s_master();
    rd_chk(RX, BYTE, 32'h0000_0022);
    irq_chk(1'b0);
    wr(i2c_dp_pkg::ADDR_CONTROL, 32'h0000_0003);
    wr(TX, 32'h0000_00C3);
    rd_chk(TX, BYTE, 32'h0000_00C3);
    rd_chk(ST, F_TXE, F_TXE);
    cond(1'b0);
    fork
      byte_x(8'hFF, 1'b1, 8'hC3, 1'b1);
      begin
        repeat (20) @(posedge clk_i);
        wr(TX, 32'h0000_005A);
      end
    join
    rd_chk(ST, F_NAK, '0);
    wr(IER, FLAGS | 32'h0000_0001);
    byte_x(8'hFF, 1'b1, 8'h5A, 1'b1);
    irq_chk(1'b1);
    wr(ST, '0);
    rd_chk(ST, F_NAK, F_NAK);
    wr(ST, '0);
    rd_chk(ST, F_NAK, '0);
    cond(1'b1);
    rd_chk(ST, F_STP, F_STP);
    wr(ST, '0);
    rd_chk(ST, F_STP, '0);
    cond(1'b0);
    cond(1'b1);
    rd_chk(ST, F_STP, '0);
    // Master receive: the block acknowledges every byte itself
    wr(i2c_dp_pkg::ADDR_CONTROL, 32'h0000_0002);
    cond(1'b0);
    byte_x(8'h3C, 1'b1, 8'h3C, 1'b0);
    rd_chk(RX, BYTE, 32'h0000_003C);
    cond(1'b1);
    rd_chk(ST, F_STP, F_STP);
  endtask
  // Main sequence
  initial
  begin
    {reset_n_i, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'h1;
    er = i2c_dp_pkg::RESP_OKAY;
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    s_reset();
    s_slave();
    s_master();
    close_out(1'b0);
  end
endmodule // i2c_data_path_bench
